// [hdl/table_skip_pkg.sv]
// Package of constants, types and the pointer step function for the table access and zero-skip block.
package table_skip_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int PTR_W      = 21;
  localparam int HOLD_N     = 8;
  localparam int HOLD_SEL_W = 3;
  localparam int BANK_W     = 4;
  localparam int DADDR_W    = 12;

  // ----------------------------------------------------------------
  // Opcode patterns and operand address limits
  // ----------------------------------------------------------------
  localparam logic [13:0] TBL_OP_HI   = 14'h0002;
  localparam logic [13:0] TBLW_OP_HI  = 14'h0003;
  localparam logic [6:0]  TSTZ_OP_HI  = 7'h33;
  localparam logic [7:0]  INDEX_LIMIT = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] PTR_RESET   = 21'h000000;
  localparam logic [7:0]       LATCH_RESET = 8'h00;
  localparam logic [7:0]       HOLD_RESET  = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_KEEP = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_POST_DEC = 2'h2,
    MODE_PRE_INC = 2'h3
  } ptr_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_TREAD = 4'b0010,
    ST_TWRITE = 4'b0100,
    ST_SKIP  = 4'b1000
  } exec_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        next_two_word;
  } instr_t;

  typedef struct packed {
    logic               req;
    logic [PTR_W-1:0]   addr;
  } pmem_req_t;

  typedef struct packed {
    logic               req;
    logic [DADDR_W-1:0] addr;
    logic               indexed;
    logic [7:0]         offset;
  } dmem_req_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
                                                input ptr_mode_t m);
    logic [PTR_W-1:0] r;
    r = p;
    case (m)
      MODE_POST_INC: r = p + 21'h000001;
      MODE_PRE_INC:  r = p + 21'h000001;
      MODE_POST_DEC: r = p - 21'h000001;
      default:       r = p;
    endcase
    return r;
  endfunction

endpackage

// [hdl/pointer_unit.sv]
// Table pointer register with mode-driven update.
module pointer_unit
  import table_skip_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             load_en,
  input  wire logic [PTR_W-1:0] load_value,
  input  wire logic             step_en,
  input  wire ptr_mode_t        mode,
  // State
  output logic [PTR_W-1:0]      ptr_value,
  output logic [PTR_W-1:0]      access_addr
);

  logic [PTR_W-1:0] ptr_reg;
  logic [PTR_W-1:0] ptr_next;

  always_comb begin
    ptr_next = ptr_reg;
    if (step_en) begin
      ptr_next = ptr_step(ptr_reg, mode);
    end else if (load_en) begin
      ptr_next = load_value;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ptr_reg <= PTR_RESET;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  assign ptr_value   = ptr_reg;
  // Pre-increment reads at the new value, the others at the old value.
  assign access_addr = (mode == MODE_PRE_INC) ? ptr_step(ptr_reg, mode) : ptr_reg;

endmodule

// [hdl/table_access_and_zero_skip.sv]
// Execution logic for table read, table write and test-zero-skip instructions.
// Functional notes
// - Table read opcode is 0000_0000_0000_10nn; nn picks pointer mode.
// - Table read copies addressed program byte to latch in second cycle.
// - Table pointer is 21 bits, addressing bytes over two megabytes.
// - Pointer bit zero picks low byte when zero, high byte when one.
// - Post modes use old pointer; pre-increment uses incremented pointer.
// - Table write opcode is 0000_0000_0000_11nn with the same modes.
// - Table write stores latch into holding register chosen by pointer bits 2:0.
// - Holding registers feed later programming; writes never touch program memory.
// - Write pointer bit zero marks word byte; pointer updates as for reads.
// - Zero operand discards next instruction as a no-op; no flags change.
// - Skipping a two-word instruction costs three cycles, both words nulled.
// - Access bit zero uses access bank; one uses bank select register.
// - Extended set, access zero, operand up to 95 uses indexed offset.
module table_access_and_zero_skip
  import table_skip_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Decoded instruction from the pipeline
  input  instr_t                instr,
  input  wire logic             ext_set_en,
  input  wire logic [BANK_W-1:0] bank_select_reg,
  // Software pointer and latch loads from the core
  input  wire logic             ptr_load_en,
  input  wire logic [PTR_W-1:0] ptr_load_value,
  input  wire logic             latch_load_en,
  input  wire logic [7:0]       latch_load_value,
  // Program memory
  input  wire logic [15:0]      pmem_word,
  output pmem_req_t             pmem_req,
  output logic                  pmem_byte_hi,
  // Data memory
  input  wire logic             dmem_valid,
  input  wire logic [7:0]       dmem_data,
  output dmem_req_t             dmem_req,
  // Pipeline control and state
  output logic                  busy,
  output logic                  flush,
  output logic [PTR_W-1:0]      table_pointer,
  output logic [7:0]            table_latch,
  output logic [HOLD_N*8-1:0]   hold_regs,
  output logic                  hold_write_pulse,
  output logic                  hold_byte_hi
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic      is_tread;
  logic      is_twrite;
  logic      is_tstz;
  ptr_mode_t op_mode;

  assign is_tread  = instr.valid && (instr.word[15:2] == TBL_OP_HI);
  assign is_twrite = instr.valid && (instr.word[15:2] == TBLW_OP_HI);
  assign is_tstz   = instr.valid && (instr.word[15:9] == TSTZ_OP_HI);
  assign op_mode   = ptr_mode_t'(instr.word[1:0]);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  exec_state_t            state_reg;
  exec_state_t            state_next;
  ptr_mode_t              mode_reg;
  ptr_mode_t              mode_next;
  logic [7:0]             latch_reg;
  logic [7:0]             latch_next;
  logic [7:0]             hold_reg [HOLD_N];
  logic [7:0]             hold_next [HOLD_N];
  logic [1:0]             skip_cnt_reg;
  logic [1:0]             skip_cnt_next;
  logic                   two_word_reg;
  logic                   two_word_next;
  pmem_req_t              pmem_req_reg;
  pmem_req_t              pmem_req_next;
  logic                   byte_hi_reg;
  logic                   byte_hi_next;
  dmem_req_t              dmem_req_reg;
  dmem_req_t              dmem_req_next;
  logic                   busy_reg;
  logic                   busy_next;
  logic                   flush_reg;
  logic                   flush_next;
  logic                   hwp_reg;
  logic                   hwp_next;
  logic                   hbh_reg;
  logic                   hbh_next;
  logic                   step_en;
  logic [PTR_W-1:0]       ptr_value;
  logic [PTR_W-1:0]       access_addr;
  logic [7:0]             f_op;
  logic                   acc_bit;

  assign f_op    = instr.word[7:0];
  assign acc_bit = instr.word[8];

  pointer_unit u_ptr (
    .clk         (clk),
    .reset       (reset),
    .load_en     (ptr_load_en),
    .load_value  (ptr_load_value),
    .step_en     (step_en),
    .mode        (mode_reg),
    .ptr_value   (ptr_value),
    .access_addr (access_addr)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_next    = state_reg;
    mode_next     = mode_reg;
    latch_next    = latch_reg;
    hold_next     = hold_reg;
    skip_cnt_next = skip_cnt_reg;
    two_word_next = two_word_reg;
    pmem_req_next = '0;
    byte_hi_next  = byte_hi_reg;
    dmem_req_next = '0;
    busy_next     = 1'b0;
    flush_next    = 1'b0;
    hwp_next      = 1'b0;
    hbh_next      = hbh_reg;
    step_en       = 1'b0;
    if (latch_load_en) begin
      latch_next = latch_load_value;
    end
    case (state_reg)
      ST_IDLE: begin
        if (is_tread) begin
          mode_next  = op_mode;
          state_next = ST_TREAD;
          busy_next  = 1'b1;
        end else if (is_twrite) begin
          mode_next  = op_mode;
          state_next = ST_TWRITE;
          busy_next  = 1'b1;
        end else if (is_tstz) begin
          dmem_req_next.req = 1'b1;
          if (!acc_bit && ext_set_en && (f_op <= INDEX_LIMIT)) begin
            dmem_req_next.indexed = 1'b1;
            dmem_req_next.offset  = f_op;
          end else if (!acc_bit) begin
            dmem_req_next.addr = (f_op < ACCESS_SPLIT) ? {4'h0, f_op}
                                                       : {ACCESS_HI_BANK, f_op};
          end else begin
            dmem_req_next.addr = {bank_select_reg, f_op};
          end
          two_word_next = instr.next_two_word;
          state_next    = ST_SKIP;
          busy_next     = 1'b1;
        end
      end
      ST_TREAD: begin
        // Second cycle: fetch the byte and load the latch.
        pmem_req_next.req  = 1'b1;
        pmem_req_next.addr = access_addr;
        byte_hi_next       = access_addr[0];
        latch_next         = access_addr[0] ? pmem_word[15:8] : pmem_word[7:0];
        step_en            = 1'b1;
        state_next         = ST_IDLE;
      end
      ST_TWRITE: begin
        // The holding register is written and the pointer steps; program memory is untouched.
        hold_next[access_addr[HOLD_SEL_W-1:0]] = latch_reg;
        hbh_next   = access_addr[0];
        hwp_next   = 1'b1;
        step_en    = 1'b1;
        state_next = ST_IDLE;
      end
      ST_SKIP: begin
        if (skip_cnt_reg != 2'h0) begin
          skip_cnt_next = skip_cnt_reg - 2'h1;
          busy_next     = (skip_cnt_reg != 2'h1);
          flush_next    = 1'b1;
          if (skip_cnt_reg == 2'h1) begin
            state_next = ST_IDLE;
          end
        end else if (dmem_valid) begin
          if (dmem_data == 8'h00) begin
            // Discard one or two fetched words as no-ops; flags untouched.
            skip_cnt_next = two_word_reg ? 2'h1 : 2'h0;
            flush_next    = 1'b1;
            busy_next     = two_word_reg;
            state_next    = two_word_reg ? ST_SKIP : ST_IDLE;
          end else begin
            state_next = ST_IDLE;
          end
        end else begin
          busy_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg    <= ST_IDLE;
      mode_reg     <= MODE_KEEP;
      latch_reg    <= LATCH_RESET;
      hold_reg     <= '{default: HOLD_RESET};
      skip_cnt_reg <= 2'h0;
      two_word_reg <= 1'b0;
      pmem_req_reg <= '0;
      byte_hi_reg  <= 1'b0;
      dmem_req_reg <= '0;
      busy_reg     <= 1'b0;
      flush_reg    <= 1'b0;
      hwp_reg      <= 1'b0;
      hbh_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      mode_reg     <= mode_next;
      latch_reg    <= latch_next;
      hold_reg     <= hold_next;
      skip_cnt_reg <= skip_cnt_next;
      two_word_reg <= two_word_next;
      pmem_req_reg <= pmem_req_next;
      byte_hi_reg  <= byte_hi_next;
      dmem_req_reg <= dmem_req_next;
      busy_reg     <= busy_next;
      flush_reg    <= flush_next;
      hwp_reg      <= hwp_next;
      hbh_reg      <= hbh_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign pmem_req         = pmem_req_reg;
  assign pmem_byte_hi     = byte_hi_reg;
  assign dmem_req         = dmem_req_reg;
  assign busy             = busy_reg;
  assign flush            = flush_reg;
  assign table_pointer    = ptr_value;
  assign table_latch      = latch_reg;
  assign hold_write_pulse = hwp_reg;
  assign hold_byte_hi     = hbh_reg;

  always_comb begin
    for (int i = 0; i < HOLD_N; i++) begin
      hold_regs[i*8 +: 8] = hold_reg[i];
    end
  end

endmodule

// [sim/mem_partner.sv]
// Behavioural program memory and data memory facing the block.
module mem_partner
  import table_skip_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Program memory
  input  wire logic [PTR_W-2:0] word_addr,
  output logic [15:0]           pmem_word,
  // Data memory
  input  dmem_req_t             dmem_req,
  input  wire logic             slow,
  input  wire logic [7:0]       operand,
  output logic                  dmem_valid,
  output logic [7:0]            dmem_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] wait_reg;
  logic [2:0] wait_next;
  logic [7:0] junk_reg;

  // Words are read only, so no path can change them.
  assign pmem_word  = {word_addr[7:0] ^ 8'h3c, word_addr[7:0]};
  assign dmem_valid = wait_reg == 3'h1;
  assign dmem_data  = dmem_valid ? operand : junk_reg;

  always_comb begin
    wait_next = wait_reg;
    if (dmem_req.req) wait_next = slow ? 3'h4 : 3'h1;
    else if (wait_reg != 3'h0) wait_next = wait_reg - 3'h1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wait_reg <= 3'h0;
      junk_reg <= 8'ha5;
    end else begin
      wait_reg <= wait_next;
      junk_reg <= ~junk_reg ^ {5'h00, wait_reg};
    end
  end
endmodule

// [sim/table_skip_sva.sv]
// Port checks for the table access and zero-skip block.
module table_skip_sva
  import table_skip_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Pipeline side
  input  instr_t                 instr,
  input  wire logic              ext_set_en,
  input  wire logic [BANK_W-1:0] bank_select_reg,
  input  wire logic              busy,
  input  wire logic              flush,
  // Memories
  input  wire logic [15:0]       pmem_word,
  input  pmem_req_t              pmem_req,
  input  wire logic              pmem_byte_hi,
  input  wire logic              dmem_valid,
  input  wire logic [7:0]        dmem_data,
  input  dmem_req_t              dmem_req,
  // State
  input  wire logic [PTR_W-1:0]  table_pointer,
  input  wire logic [7:0]        table_latch,
  input  wire logic              hold_write_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic              idle, rd_take, wr_take, tz_take;
  logic [15:0]       word_q;
  logic [7:0]        f_q;
  logic [BANK_W-1:0] bank_q;

  assign idle    = instr.valid && !busy && !flush;
  assign rd_take = idle && instr.word[15:2] == TBL_OP_HI;
  assign wr_take = idle && instr.word[15:2] == TBLW_OP_HI;
  assign tz_take = idle && instr.word[15:9] == TSTZ_OP_HI;

  always_ff @(posedge clk) begin
    word_q <= pmem_word;
    f_q    <= instr.word[7:0];
    bank_q <= bank_select_reg;
  end

  read_done_a: assert property (rd_take |=> busy ##1 pmem_req.req && !busy)
    else $error("table read did not finish in two cycles");
  byte_lane_a: assert property (pmem_req.req |-> pmem_byte_hi == pmem_req.addr[0] &&
    table_latch == (pmem_req.addr[0] ? word_q[15:8] : word_q[7:0]))
    else $error("wrong byte lane taken");
  post_addr_a: assert property (rd_take && instr.word[1:0] != 2'h3 |-> ##2
    pmem_req.addr == $past(table_pointer, 2)) else $error("post mode read address wrong");
  pre_addr_a: assert property (rd_take && instr.word[1:0] == 2'h3 |-> ##2
    pmem_req.addr == table_pointer) else $error("pre increment read address wrong");
  ptr_inc_a: assert property ((rd_take || wr_take) && instr.word[0] |-> ##2
    table_pointer == $past(table_pointer, 2) + 21'h000001) else $error("pointer not incremented");
  ptr_dec_a: assert property ((rd_take || wr_take) && instr.word[1:0] == 2'h2 |-> ##2
    table_pointer == $past(table_pointer, 2) - 21'h000001) else $error("pointer not decremented");
  hold_write_a: assert property (wr_take |=> busy ##1 !pmem_req.req ##[0:1] hold_write_pulse)
    else $error("table write did not reach a holding register");
  bank_addr_a: assert property (tz_take && instr.word[8] |=> dmem_req.req &&
    dmem_req.addr == {bank_q, f_q}) else $error("bank select address wrong");
  indexed_a: assert property (tz_take && !instr.word[8] && ext_set_en &&
    instr.word[7:0] <= INDEX_LIMIT |=> dmem_req.req && dmem_req.indexed && dmem_req.offset == f_q)
    else $error("indexed offset mode not used");
  skip_zero_a: assert property (busy && dmem_valid && dmem_data == 8'h00 |=> flush)
    else $error("zero operand did not discard next word");
  access_bank_a: assert property (tz_take && !instr.word[8] &&
    !(ext_set_en && instr.word[7:0] <= INDEX_LIMIT) |=> dmem_req.req && !dmem_req.indexed &&
    dmem_req.addr == ((f_q < ACCESS_SPLIT) ? {4'h0, f_q} : {ACCESS_HI_BANK, f_q}))
    else $error("access bank address wrong");

  cover property (rd_take && instr.word[1:0] == 2'h3);
  cover property (wr_take);
  cover property (tz_take && instr.next_two_word);
endmodule

bind table_access_and_zero_skip table_skip_sva i_table_skip_sva (.clk(clk), .reset(reset),
  .instr(instr), .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .busy(busy),
  .flush(flush), .pmem_word(pmem_word), .pmem_req(pmem_req), .pmem_byte_hi(pmem_byte_hi),
  .dmem_valid(dmem_valid), .dmem_data(dmem_data), .dmem_req(dmem_req),
  .table_pointer(table_pointer), .table_latch(table_latch), .hold_write_pulse(hold_write_pulse));

// [sim/table_access_and_zero_skip_tb.sv]
// Self-checking bench for the table access and zero-skip block.
module table_access_and_zero_skip_tb
  import table_skip_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [15:0] word; logic [20:0] start; logic [7:0] data; logic [20:0] ptr; logic [7:0] val;
  } row_t;
  typedef struct packed {
    logic [15:0] word; logic ext; logic two; logic slow; logic [7:0] opnd; logic [1:0] nfl;
  } skip_t;

  logic clk, reset, ext_set_en, ptr_load_en, latch_load_en, pmem_byte_hi, dmem_valid, busy;
  logic flush, hold_write_pulse, hold_byte_hi, slow;
  logic [BANK_W-1:0] bank_select_reg;
  logic [PTR_W-1:0] ptr_load_value, table_pointer, acc;
  logic [PTR_W-2:0] word_addr;
  logic [7:0] latch_load_value, dmem_data, table_latch, operand;
  logic [15:0] pmem_word;
  logic [63:0] hold_regs;
  instr_t instr;
  pmem_req_t pmem_req;
  dmem_req_t dmem_req;
  int bad_count, comparisons, nf;

  row_t rows[9] = '{
    '{16'h0008, 21'h00a356, 8'h00, 21'h00a356, 8'hab}, '{16'h0009, 21'h00a357, 8'h00, 21'h00a358, 8'h97},
    '{16'h000a, 21'h000000, 8'h00, 21'h1fffff, 8'h00}, '{16'h000b, 21'h01a357, 8'h00, 21'h01a358, 8'hac},
    '{16'h000b, 21'h1fffff, 8'h00, 21'h000000, 8'h00}, '{16'h000c, 21'h01389a, 8'h34, 21'h01389a, 8'h34},
    '{16'h000d, 21'h000007, 8'h55, 21'h000008, 8'h55}, '{16'h000e, 21'h000000, 8'h66, 21'h1fffff, 8'h66},
    '{16'h000f, 21'h01389a, 8'h77, 21'h01389b, 8'h77}};
  skip_t skips[5] = '{'{16'h6610, 1'b0, 1'b0, 1'b0, 8'h00, 2'h1},
    '{16'h6710, 1'b0, 1'b1, 1'b1, 8'h00, 2'h2}, '{16'h66f0, 1'b0, 1'b0, 1'b1, 8'h5a, 2'h0},
    '{16'h665f, 1'b1, 1'b1, 1'b0, 8'h00, 2'h2}, '{16'h6660, 1'b1, 1'b0, 1'b0, 8'h00, 2'h1}};

  table_access_and_zero_skip i_table_access_and_zero_skip (.clk(clk), .reset(reset), .instr(instr),
    .ext_set_en(ext_set_en), .bank_select_reg(bank_select_reg), .ptr_load_en(ptr_load_en),
    .ptr_load_value(ptr_load_value), .latch_load_en(latch_load_en),
    .latch_load_value(latch_load_value), .pmem_word(pmem_word), .pmem_req(pmem_req),
    .pmem_byte_hi(pmem_byte_hi), .dmem_valid(dmem_valid), .dmem_data(dmem_data),
    .dmem_req(dmem_req), .busy(busy), .flush(flush), .table_pointer(table_pointer),
    .table_latch(table_latch), .hold_regs(hold_regs), .hold_write_pulse(hold_write_pulse),
    .hold_byte_hi(hold_byte_hi));
  mem_partner i_mem_partner (.clk(clk), .reset(reset), .word_addr(word_addr),
    .pmem_word(pmem_word), .dmem_req(dmem_req), .slow(slow), .operand(operand),
    .dmem_valid(dmem_valid), .dmem_data(dmem_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Offers one instruction, then waits for the block to return idle, counting discards.
  task automatic run(input logic [15:0] w, input logic two, output int nflush);
    int n;
    nflush = 0;
    @(posedge clk);
    instr <= {1'b1, w, two};
    @(posedge clk);
    instr.valid <= 1'b0;
    for (n = 0; n < 30; n++) begin
      @(negedge clk);
      nflush += flush;
      if (!busy && !flush) break;
    end
    if (n == 30) begin
      bad_count++;
      final_report();
    end
  endtask

  initial begin
    {reset, ext_set_en, ptr_load_en, latch_load_en, slow} = 5'h10;
    instr = '0;
    bank_select_reg = 4'h5;
    {ptr_load_value, latch_load_value, operand, word_addr} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check(table_pointer, PTR_RESET);
    check(hold_regs, {HOLD_N{HOLD_RESET}});
    check({table_latch, busy, flush}, 10'h000);
    $display("reset test done");
    foreach (rows[i]) begin
      acc = rows[i].word[1:0] == 2'h3 ? rows[i].start + 21'h000001 : rows[i].start;
      @(posedge clk);
      {ptr_load_en, latch_load_en} <= 2'h3;
      ptr_load_value <= rows[i].start;
      latch_load_value <= rows[i].data;
      word_addr <= acc[20:1];
      @(posedge clk);
      {ptr_load_en, latch_load_en} <= 2'h0;
      run(rows[i].word, 1'b0, nf);
      if (rows[i].word[2]) check(hold_regs[8*acc[2:0] +: 8], rows[i].val);
      else check(table_latch, rows[i].val);
      check(table_pointer, rows[i].ptr);
      check(rows[i].word[2] ? hold_byte_hi : pmem_byte_hi, acc[0]);
    end
    $display("table access test done");
    foreach (skips[i]) begin
      ext_set_en <= skips[i].ext;
      slow <= skips[i].slow;
      operand <= skips[i].opnd;
      run(skips[i].word, skips[i].two, nf);
      check(nf, skips[i].nfl);
      check(table_pointer, 21'h01389b);
    end
    $display("zero skip test done");
    @(posedge clk);
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    ptr_load_en <= 1'b1;
    ptr_load_value <= 21'h000025;
    word_addr <= 20'h00012;
    @(negedge clk);
    check(table_pointer, PTR_RESET);
    check(hold_regs, {HOLD_N{HOLD_RESET}});
    check({table_latch, busy, flush, pmem_byte_hi, hold_write_pulse, hold_byte_hi}, 64'h0);
    check({pmem_req, dmem_req}, 64'h0);
    @(posedge clk);
    ptr_load_en <= 1'b0;
    instr <= {1'b1, 16'h0009, 1'b0};
    @(posedge clk);
    instr.valid <= 1'b0;
    {ptr_load_en, latch_load_en} <= 2'h3;
    ptr_load_value <= 21'h1aaaaa;
    latch_load_value <= 8'hc3;
    @(posedge clk);
    {ptr_load_en, latch_load_en} <= 2'h0;
    @(negedge clk);
    check(table_latch, 8'h2e);
    check(table_pointer, 21'h000026);
    check(pmem_byte_hi, 1'b1);
    check(busy, 1'b0);
    $display("reset and load override test done");
    final_report();
  end
endmodule
